// *** bench/cbi_core_bus_interface_sva.sv ***
// checker: port-level assertions for the core bus interface
`timescale 1ns/1ps
module cbi_core_bus_interface_sva
  import cbi_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              if_req,
  input wire logic              if_valid,
  input wire logic              ld_req,
  input wire logic              ld_valid,
  input wire logic              core_stall,
  input wire logic [1:0]        port_width,
  input wire logic              bus_req,
  input wire logic              bus_write,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic [3:0]        bus_be,
  input wire logic              bus_ack
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |-> !bus_req && !if_valid && !ld_valid && !core_stall)
    else $error("outputs active during reset");
  a_req_hold: assert property (
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr)
      && $stable(bus_write))
    else $error("request dropped or changed before ack");
  a_wdata_hold: assert property (
    bus_req && bus_write && !bus_ack |=> $stable(bus_wdata)
      && $stable(bus_be))
    else $error("write data moved before ack");
  a_lane_byte: assert property (
    bus_req && bus_write && port_width == CBI_PW_8 |-> bus_be == 4'h1)
    else $error("byte port write not on lane 0");
  a_lane_half: assert property (
    bus_req && bus_write && port_width == CBI_PW_16
      |-> bus_be[3:2] == 2'h0 && bus_be[1:0] != 2'h0)
    else $error("half port write outside low lanes");
  a_read_align: assert property (
    bus_req && !bus_write && port_width == CBI_PW_32
      |-> bus_addr[1:0] == 2'h0)
    else $error("word port read not word aligned");
  a_fetch_cause: assert property (
    if_valid |-> $past(if_req))
    else $error("fetch data without fetch request");
  a_load_cause: assert property (
    ld_valid |-> $past(ld_req))
    else $error("load data without load request");
endmodule : cbi_core_bus_interface_sva

// *** bench/cbi_ctrl_model.sv ***
// partner: behavioural bus controller behind the common request port
`timescale 1ns/1ps
module cbi_ctrl_model
  import cbi_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  ack_wait,
  input  wire logic [1:0]  port_width,
  input  wire logic        bus_req,
  input  wire logic        bus_write,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic [3:0]  bus_be,
  output logic             bus_ack,
  output logic [31:0]      bus_rdata
);
  logic [31:0] wa_q[$];
  logic [31:0] wd_q[$];
  int          rd_cnt;
  logic [3:0]  cnt;

  function automatic logic [31:0] memw(input logic [31:0] a);
    return {a[15:2], 2'h3, ~a[17:2]} ^ 32'h5A3C_96E1;
  endfunction : memw

  // narrow ports answer in the low lanes; the upper lanes carry junk
  function automatic logic [31:0] rd_val(input logic [31:0] a);
    logic [31:0] w;
    w = memw({a[31:2], 2'h0}) >> {a[1:0], 3'h0};
    if (port_width == CBI_PW_8)
      return {~a[23:0], w[7:0]};
    if (port_width == CBI_PW_16)
      return {~a[15:0], w[15:0]};
    return w;
  endfunction : rd_val

  ////////////////////////////////////////////////////////////////////////////
  // one ack pulse per beat after ack_wait idle cycles
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_ack   <= 1'b0;
      cnt       <= 4'h0;
      bus_rdata <= 32'h0;
    end else if (bus_ack) begin
      bus_ack   <= 1'b0;
      bus_rdata <= ~bus_rdata;
    end else if (bus_req && cnt == ack_wait) begin
      bus_ack   <= 1'b1;
      cnt       <= 4'h0;
      bus_rdata <= rd_val(bus_addr);
    end else begin
      cnt       <= bus_req ? cnt + 4'h1 : 4'h0;
      bus_rdata <= ~bus_rdata;
    end
  end

  // log each beat at the edge where the ack is taken
  always @(posedge core_clk) begin
    if (bus_ack && bus_write) begin
      wa_q.push_back(bus_addr);
      wd_q.push_back(bus_wdata);
    end else if (bus_ack) begin
      rd_cnt++;
    end
  end
endmodule : cbi_ctrl_model

// *** bench/tb.sv ***
// testbench: random and corner-case traffic through the bus interface
`timescale 1ns/1ps
module tb;
  import cbi_pkg::*;
  logic        core_clk = 1'b0, sys_rst = 1'b0;
  logic [1:0]  icache_part = 2'h0, dcache_part = 2'h0, port_width = 2'h2;
  logic        if_req = 1'b0, ld_req = 1'b0, st_req = 1'b0;
  logic [31:0] if_addr = 32'h0, d_addr = 32'h0, d_wdata = 32'h0;
  logic [1:0]  d_size = 2'h2;
  logic [3:0]  ack_wait = 4'h0;
  logic        if_valid, ld_valid, core_stall, bus_req, bus_write, bus_ack;
  logic [31:0] if_data, ld_data, bus_addr, bus_wdata, bus_rdata;
  logic [3:0]  bus_be;
  logic [31:0] a, d, q, m, ea[6], ed[6];
  int          n, nb, nq, nmax, error_cnt, cmp_count;
  integer      seed = 48;

  always #25 core_clk = ~core_clk;

  cbi_core_bus_interface dut (.core_clk, .sys_rst, .icache_part,
    .dcache_part, .if_req, .if_addr, .if_valid, .if_data, .ld_req, .st_req,
    .d_addr, .d_wdata, .d_size, .ld_valid, .ld_data, .core_stall,
    .port_width, .bus_req, .bus_write, .bus_addr, .bus_wdata, .bus_be,
    .bus_ack, .bus_rdata);
  cbi_ctrl_model pm (.core_clk, .sys_rst, .ack_wait, .port_width, .bus_req,
    .bus_write, .bus_addr, .bus_wdata, .bus_be, .bus_ack, .bus_rdata);

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk

  task automatic tick;
    @(posedge core_clk);
    #2;
  endtask : tick

  // st_req stays up so stores can go back to back; caller lowers it
  // core_stall after an edge tells whether the store offered there was taken
  task automatic store(input logic [31:0] sa, sd, output int cyc);
    st_req = 1'b1;
    d_addr = sa;
    d_wdata = sd;
    d_size = SIZE_WORD;
    for (cyc = 1; cyc < 300; cyc++) begin
      tick();
      if (core_stall === 1'b0) break;
    end
    if (cyc == 300) begin
      chk(1'b0, "store never taken");
      results();
    end
  endtask : store

  task automatic access(input bit ld, input logic [31:0] xa,
                        output logic [31:0] xd);
    if (ld) begin
      ld_req = 1'b1;
      d_addr = xa;
      d_size = SIZE_WORD;
    end else begin
      if_req = 1'b1;
      if_addr = xa;
    end
    repeat (400) begin
      tick();
      if ((ld ? ld_valid : if_valid) === 1'b1) break;
    end
    if ((ld ? ld_valid : if_valid) !== 1'b1) begin
      chk(1'b0, "read never answered");
      results();
    end
    xd = ld ? ld_data : if_data;
    ld_req = 1'b0;
    if_req = 1'b0;
    tick();
  endtask : access

  task automatic wait_wr(input int cnt);
    repeat (600) begin
      if (pm.wa_q.size() >= cnt) break;
      tick();
    end
    chk(pm.wa_q.size() == cnt, "write beat count");
    if (pm.wa_q.size() < cnt) results();
  endtask : wait_wr

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1 sys_rst = 1'b1;
    repeat (20) @(posedge core_clk);
    #2 sys_rst = 1'b0;
    tick();
    // slow controller so the queue fills and must stall the fifth store
    ack_wait = 4'h6;
    nmax = 0;
    for (int i = 0; i < 6; i++) begin
      ea[i] = $random(seed) & 32'hFFFF_FFFC;
      ed[i] = $random(seed);
      store(ea[i], ed[i], n);
      if (i < 4) chk(n == 1, "store stalled with room");
      if (n > nmax) nmax = n;
    end
    st_req = 1'b0;
    tick();
    chk(nmax > 1, "no stall with full queue");
    wait_wr(6);
    for (int i = 0; i < 6; i++)
      chk(pm.wa_q[i] === ea[i] && pm.wd_q[i] === ed[i], "order");
    // every port width: splitting, quad fetch, single load
    ack_wait = 4'h1;
    for (int p = 0; p < 4; p++) begin
      port_width = p[1:0];
      pm.wa_q.delete();
      pm.wd_q.delete();
      a = $random(seed) & 32'hFFFF_FFF0;
      d = $random(seed);
      nb = (p == 0) ? 4 : (p == 1) ? 2 : 1;
      store(a, d, n);
      st_req = 1'b0;
      tick();
      wait_wr(nb);
      m = 32'hFFFF_FFFF >> (32 - 32 / nb);
      for (int i = 0; i < nb; i++)
        chk(pm.wa_q[i] === a + 4 / nb * i && (pm.wd_q[i] & m)
            === ((d >> (32 / nb * i)) & m), "split beat");
      pm.rd_cnt = 0;
      a = $random(seed) & 32'hFFFF_FFF0;
      access(0, a + 8, q);
      chk(q === pm.memw(a + 8), "fetch miss data");
      chk(pm.rd_cnt == 4 * nb, "quad read beats");
      for (int k = 0; k < 4; k++) begin
        access(0, a + 4 * k, q);
        chk(q === pm.memw(a + 4 * k), "line word");
      end
      chk(pm.rd_cnt == 4 * nb, "bus used on fetch hit");
      pm.rd_cnt = 0;
      a = $random(seed) & 32'hFFFF_FFFC;
      access(1, a, q);
      chk(q === pm.memw(a) && pm.rd_cnt == nb, "load miss");
      access(1, a, q);
      chk(q === pm.memw(a) && pm.rd_cnt == nb, "load hit");
    end
    // two regions sharing an index survive together once partitioned
    port_width = CBI_PW_32;
    icache_part = CBI_PART_QUARTER;
    dcache_part = CBI_PART_HALF;
    for (int k = 0; k < 2; k++) begin
      access(k[0], 32'h0000_0340, q);
      access(k[0], 32'h1000_0340, q);
      nq = pm.rd_cnt;
      access(k[0], 32'h0000_0340, q);
      chk(pm.rd_cnt == nq && q === pm.memw(32'h340), "partition");
    end
    results();
  end

  initial begin
    #(50 * 100000);
    chk(1'b0, "run limit reached");
    results();
  end
endmodule : tb

bind cbi_core_bus_interface cbi_core_bus_interface_sva u_sva (.core_clk,
  .sys_rst, .if_req, .if_valid, .ld_req, .ld_valid, .core_stall,
  .port_width, .bus_req, .bus_write, .bus_addr, .bus_wdata, .bus_be,
  .bus_ack);

// *** rtl/cbi_cache.sv ***
// direct-mapped tag/data store with region partitioning
`timescale 1ns/1ps
module cbi_cache #(
  parameter int LINES   = 256,
  parameter int IDX_W   = 8,
  parameter int IDX_LSB = 2,
  parameter int TAG_LSB = 10,
  parameter int TAG_W   = 22
) (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic [1:0]                part,
  input  wire logic [cbi_pkg::ADDR_W-1:0] lk_addr,
  output logic                           lk_hit,
  output logic [cbi_pkg::DATA_W-1:0]     lk_data,
  input  wire logic                      wr_en,
  input  wire logic [cbi_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [cbi_pkg::DATA_W-1:0] wr_data
);
  import cbi_pkg::*;

  logic [TAG_W-1:0]  tag_mem [LINES];
  logic [DATA_W-1:0] dat_mem [LINES];
  logic [LINES-1:0]  valid;
  logic [IDX_W-1:0]  lk_idx;
  logic [IDX_W-1:0]  wr_idx;

  // partitioning swaps top index bits for address-region bits, so each
  // region owns a fixed slice; tag still starts at TAG_LSB, so the dropped index bits go unchecked and can alias
  function automatic logic [IDX_W-1:0] index_of(
    input logic [ADDR_W-1:0] a, input logic [1:0] p);
    logic [IDX_W-1:0] i;
    i = a[IDX_LSB +: IDX_W];
    case (p)
      CBI_PART_HALF:    i[IDX_W-1]   = a[SEG_LSB];
      CBI_PART_QUARTER: i[IDX_W-1 -: 2] = a[SEG_LSB +: 2];
      default:          i = a[IDX_LSB +: IDX_W];
    endcase
    return i;
  endfunction : index_of

  assign lk_idx  = index_of(lk_addr, part);
  assign wr_idx  = index_of(wr_addr, part);
  // physical tag compare only; no context id so no flush needed
  assign lk_hit  = valid[lk_idx] &&
                   (tag_mem[lk_idx] == lk_addr[TAG_LSB +: TAG_W]);
  assign lk_data = dat_mem[lk_idx];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      tag_mem[wr_idx] <= wr_addr[TAG_LSB +: TAG_W];
      dat_mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) valid <= '0;
    else if (wr_en) valid[wr_idx] <= 1'b1;
  end
endmodule : cbi_cache

// *** rtl/cbi_core_bus_interface.sv ***
// core bus interface unit: caches, write queue, read buffer, packing
`timescale 1ns/1ps
module cbi_core_bus_interface (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  // cache configuration
  input  wire logic [1:0]                 icache_part,
  input  wire logic [1:0]                 dcache_part,
  // core instruction fetch
  input  wire logic                       if_req,
  input  wire logic [cbi_pkg::ADDR_W-1:0] if_addr,
  output logic                            if_valid,
  output logic [cbi_pkg::DATA_W-1:0]      if_data,
  // core data access
  input  wire logic                       ld_req,
  input  wire logic                       st_req,
  input  wire logic [cbi_pkg::ADDR_W-1:0] d_addr,
  input  wire logic [cbi_pkg::DATA_W-1:0] d_wdata,
  input  wire logic [1:0]                 d_size,
  output logic                            ld_valid,
  output logic [cbi_pkg::DATA_W-1:0]      ld_data,
  output logic                            core_stall,
  // controller side: common request port
  input  wire logic [1:0]                 port_width,
  output logic                            bus_req,
  output logic                            bus_write,
  output logic [cbi_pkg::ADDR_W-1:0]      bus_addr,
  output logic [cbi_pkg::DATA_W-1:0]      bus_wdata,
  output logic [3:0]                      bus_be,
  input  wire logic                       bus_ack,
  input  wire logic [cbi_pkg::DATA_W-1:0] bus_rdata
);
  import cbi_pkg::*;

  typedef enum logic [4:0] {
    CBI_IDLE  = 5'h01,
    CBI_WRITE = 5'h02,
    CBI_READ  = 5'h04,
    CBI_FILL  = 5'h08,
    CBI_DONE  = 5'h10
  } cbi_state_t;

  cbi_state_t        state;
  // write queue
  logic              wq_full;
  logic              wq_empty;
  logic              wq_pop;
  logic              wq_push;
  logic [ADDR_W-1:0] wq_addr;
  logic [DATA_W-1:0] wq_data;
  logic [1:0]        wq_size;
  // caches
  logic              ic_hit;
  logic [DATA_W-1:0] ic_rdata;
  logic              ic_wr;
  logic [ADDR_W-1:0] ic_waddr;
  logic              dc_hit;
  logic [DATA_W-1:0] dc_rdata;
  logic              dc_wr;
  logic [ADDR_W-1:0] dc_waddr;
  logic [DATA_W-1:0] dc_wdata;
  // read path
  logic              rd_is_ifetch;
  logic [ADDR_W-1:0] rd_addr;
  logic [1:0]        word_cnt;
  logic [1:0]        beat_cnt;
  logic [1:0]        fill_cnt;
  logic [DATA_W-1:0] pack_word;
  logic [DATA_W-1:0] rbuf [RB_DEPTH];
  // write split
  logic [1:0]        wr_beat;
  logic [1:0]        wr_beats;
  logic [1:0]        beats_per_word;
  logic              if_miss;
  logic              ld_miss;

  ////////////////////////////////////////////////////////////////////////////
  // caches and write queue

  cbi_cache #(
    .LINES   (IC_LINES),
    .IDX_W   (IC_IDX_W),
    .IDX_LSB (IC_IDX_LSB),
    .TAG_LSB (IC_TAG_LSB),
    .TAG_W   (IC_TAG_W)
  ) u_icache (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .part     (icache_part),
    .lk_addr  (if_addr),
    .lk_hit   (ic_hit),
    .lk_data  (),
    .wr_en    (ic_wr),
    .wr_addr  (ic_waddr),
    .wr_data  (rbuf[fill_cnt])
  );

  // the icache line valid/tag is per line; words sit in a word array here
  logic [DATA_W-1:0] ic_words [IC_LINES*RB_DEPTH];
  logic [IC_IDX_W+1:0] ic_word_idx;
  logic [IC_IDX_W+1:0] ic_fill_idx;

  function automatic logic [IC_IDX_W-1:0] ic_line(
    input logic [ADDR_W-1:0] a, input logic [1:0] p);
    logic [IC_IDX_W-1:0] i;
    i = a[IC_IDX_LSB +: IC_IDX_W];
    case (p)
      CBI_PART_HALF:    i[IC_IDX_W-1] = a[SEG_LSB];
      CBI_PART_QUARTER: i[IC_IDX_W-1 -: 2] = a[SEG_LSB +: 2];
      default:          i = a[IC_IDX_LSB +: IC_IDX_W];
    endcase
    return i;
  endfunction : ic_line

  assign ic_word_idx = {ic_line(if_addr, icache_part),
                        if_addr[WORD_LSB +: 2]};
  assign ic_fill_idx = {ic_line(ic_waddr, icache_part), fill_cnt};
  assign ic_rdata    = ic_words[ic_word_idx];

  always_ff @(posedge core_clk) begin
    if (state == CBI_FILL) ic_words[ic_fill_idx] <= rbuf[fill_cnt];
  end

  cbi_cache #(
    .LINES   (DC_LINES),
    .IDX_W   (DC_IDX_W),
    .IDX_LSB (DC_IDX_LSB),
    .TAG_LSB (DC_TAG_LSB),
    .TAG_W   (DC_TAG_W)
  ) u_dcache (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .part     (dcache_part),
    .lk_addr  (d_addr),
    .lk_hit   (dc_hit),
    .lk_data  (dc_rdata),
    .wr_en    (dc_wr),
    .wr_addr  (dc_waddr),
    .wr_data  (dc_wdata)
  );

  cbi_write_queue u_wq (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .push      (wq_push),
    .push_addr (d_addr),
    .push_data (d_wdata),
    .push_size (d_size),
    .pop       (wq_pop),
    .full      (wq_full),
    .empty     (wq_empty),
    .head_addr (wq_addr),
    .head_data (wq_data),
    .head_size (wq_size)
  );

  ////////////////////////////////////////////////////////////////////////////
  // core-side hit path

  assign if_miss = if_req && !ic_hit;
  assign ld_miss = ld_req && !dc_hit;
  assign wq_push = st_req && !wq_full;

  // of the stores only word stores update the dcache; partial stores invalidate nothing,
  // so they write through and the line is refreshed on a later word store
  assign ic_wr    = (state == CBI_FILL) && (fill_cnt == 2'(RB_DEPTH-1));
  assign ic_waddr = rd_addr;
  assign dc_wr    = (st_req && !wq_full && d_size == SIZE_WORD) ||
                    (state == CBI_DONE && !rd_is_ifetch);
  assign dc_waddr = (state == CBI_DONE) ? rd_addr : d_addr;
  assign dc_wdata = (state == CBI_DONE) ? rbuf[0] : d_wdata;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      if_valid <= 1'b0;
      if_data  <= '0;
      ld_valid <= 1'b0;
      ld_data  <= '0;
    end else begin
      if_valid <= if_req && ic_hit;
      if_data  <= ic_rdata;
      ld_valid <= ld_req && dc_hit;
      ld_data  <= dc_rdata;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) core_stall <= 1'b0;
    // flags a store refused at this edge or a miss still outstanding;
    // draining queued writes must not hold up hits or further stores
    else core_stall <= (st_req && wq_full) || if_miss || ld_miss;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus sequencer

  always_comb begin
    case (port_width)
      CBI_PW_8:  beats_per_word = 2'h3;
      CBI_PW_16: beats_per_word = 2'h1;
      default:   beats_per_word = 2'h0;
    endcase
  end

  // a byte store needs one beat; a half two beats on an 8-bit port
  always_comb begin
    case (wq_size)
      SIZE_BYTE: wr_beats = 2'h0;
      SIZE_HALF: wr_beats = (port_width == CBI_PW_8) ? 2'h1 : 2'h0;
      default:   wr_beats = beats_per_word;
    endcase
  end

  assign wq_pop = (state == CBI_WRITE) && bus_ack && (wr_beat == wr_beats);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= CBI_IDLE;
      rd_is_ifetch <= 1'b0;
      rd_addr      <= '0;
      word_cnt     <= '0;
      beat_cnt     <= '0;
      fill_cnt     <= '0;
      wr_beat      <= '0;
    end else begin
      case (state)
        CBI_IDLE: begin
          // queued writes drain first so a load sees memory up to date
          if (!wq_empty) begin
            state   <= CBI_WRITE;
            wr_beat <= '0;
          end else if (if_miss) begin
            state        <= CBI_READ;
            rd_is_ifetch <= 1'b1;
            rd_addr      <= {if_addr[ADDR_W-1:IC_IDX_LSB],
                             IC_IDX_LSB'(0)};
            word_cnt     <= '0;
            beat_cnt     <= '0;
          end else if (ld_miss) begin
            state        <= CBI_READ;
            rd_is_ifetch <= 1'b0;
            rd_addr      <= {d_addr[ADDR_W-1:WORD_LSB], WORD_LSB'(0)};
            word_cnt     <= '0;
            beat_cnt     <= '0;
          end
        end
        CBI_WRITE: begin
          if (bus_ack) begin
            if (wr_beat == wr_beats) state <= CBI_IDLE;
            else wr_beat <= wr_beat + 1'b1;
          end
        end
        CBI_READ: begin
          if (bus_ack) begin
            if (beat_cnt == beats_per_word) begin
              beat_cnt <= '0;
              if (!rd_is_ifetch) state <= CBI_DONE;
              else if (word_cnt == 2'(RB_DEPTH-1)) begin
                state    <= CBI_FILL;
                fill_cnt <= '0;
              end else word_cnt <= word_cnt + 1'b1;
            end else beat_cnt <= beat_cnt + 1'b1;
          end
        end
        CBI_FILL: begin
          if (fill_cnt == 2'(RB_DEPTH-1)) state <= CBI_IDLE;
          else fill_cnt <= fill_cnt + 1'b1;
        end
        CBI_DONE: state <= CBI_IDLE;
        default:  state <= CBI_IDLE;
      endcase
    end
  end

  // narrow beats are shifted into place within the word being assembled
  always_comb begin
    pack_word = rbuf[word_cnt];
    case (port_width)
      CBI_PW_8:  pack_word[beat_cnt*8 +: 8]   = bus_rdata[7:0];
      CBI_PW_16: pack_word[beat_cnt[0]*16 +: 16] = bus_rdata[15:0];
      default:   pack_word = bus_rdata;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (state == CBI_READ && bus_ack) rbuf[word_cnt] <= pack_word;
  end

  ////////////////////////////////////////////////////////////////////////////
  // controller request port, registered

  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_wdata;
  logic [3:0]        next_be;
  logic [1:0]        lane;

  always_comb begin
    next_addr  = rd_addr;
    next_wdata = '0;
    next_be    = 4'hF;
    lane       = '0;
    if (state == CBI_WRITE || (state == CBI_IDLE && !wq_empty)) begin
      lane = wq_addr[1:0] + ((state != CBI_WRITE) ? 2'h0 :
             (port_width == CBI_PW_16) ? {wr_beat[0], 1'b0} : wr_beat);
      case (port_width)
        CBI_PW_8: begin
          next_addr  = {wq_addr[ADDR_W-1:2], lane};
          next_wdata = {24'h0, wq_data[lane*8 +: 8]};
          next_be    = 4'h1;
        end
        CBI_PW_16: begin
          next_addr  = {wq_addr[ADDR_W-1:2], lane[1], 1'b0};
          next_wdata = {16'h0, wq_data[lane[1]*16 +: 16]};
          next_be    = (wq_size == SIZE_BYTE) ? (4'h1 << lane[0]) : 4'h3;
        end
        default: begin
          next_addr  = wq_addr;
          next_wdata = wq_data;
          case (wq_size)
            SIZE_BYTE: next_be = 4'h1 << wq_addr[1:0];
            SIZE_HALF: next_be = wq_addr[1] ? 4'hC : 4'h3;
            default:   next_be = 4'hF;
          endcase
        end
      endcase
    end else begin
      case (port_width)
        CBI_PW_8:  next_addr = {rd_addr[ADDR_W-1:4], word_cnt, beat_cnt};
        CBI_PW_16: next_addr = {rd_addr[ADDR_W-1:4], word_cnt,
                                beat_cnt[0], 1'b0};
        default:   next_addr = {rd_addr[ADDR_W-1:4], word_cnt, 2'h0};
      endcase
      if (!rd_is_ifetch) next_addr[3:2] = rd_addr[3:2];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_req   <= 1'b0;
      bus_write <= 1'b0;
      bus_addr  <= '0;
      bus_wdata <= '0;
      bus_be    <= '0;
    end else begin
      // idle one cycle after each ack so the next beat's address settles
      bus_req   <= (state == CBI_WRITE || state == CBI_READ) &&
                   !bus_ack;
      bus_write <= (state == CBI_WRITE);
      bus_addr  <= next_addr;
      bus_wdata <= next_wdata;
      bus_be    <= next_be;
    end
  end
endmodule : cbi_core_bus_interface

// *** rtl/cbi_pkg.sv ***
// package: constants and types shared by the core bus interface unit
package cbi_pkg;
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int WQ_DEPTH    = 4;
  localparam int WQ_PTR_W    = 2;
  localparam int RB_DEPTH    = 4;
  localparam int IC_LINES    = 256;   // 4KB / 16-byte lines
  localparam int IC_IDX_W    = 8;
  localparam int IC_IDX_LSB  = 4;
  localparam int IC_TAG_LSB  = 12;
  localparam int IC_TAG_W    = 20;
  localparam int DC_LINES    = 256;   // 1KB / 4-byte lines
  localparam int DC_IDX_W    = 8;
  localparam int DC_IDX_LSB  = 2;
  localparam int DC_TAG_LSB  = 10;
  localparam int DC_TAG_W    = 22;
  localparam int WORD_LSB    = 2;
  localparam int SEG_LSB     = 28;    // region bits pick a cache section

  // memory port width codes
  typedef enum logic [1:0] {
    CBI_PW_8  = 2'h0,
    CBI_PW_16 = 2'h1,
    CBI_PW_32 = 2'h2,
    CBI_PW_IL = 2'h3
  } cbi_width_t;

  // cache partition codes
  typedef enum logic [1:0] {
    CBI_PART_FULL    = 2'h0,
    CBI_PART_HALF    = 2'h1,
    CBI_PART_QUARTER = 2'h2
  } cbi_part_t;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
endpackage : cbi_pkg

// *** rtl/cbi_write_queue.sv ***
// write queue: four-entry fifo of store address, data and size
`timescale 1ns/1ps
module cbi_write_queue (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      push,
  input  wire logic [cbi_pkg::ADDR_W-1:0] push_addr,
  input  wire logic [cbi_pkg::DATA_W-1:0] push_data,
  input  wire logic [1:0]                push_size,
  input  wire logic                      pop,
  output logic                           full,
  output logic                           empty,
  output logic [cbi_pkg::ADDR_W-1:0]     head_addr,
  output logic [cbi_pkg::DATA_W-1:0]     head_data,
  output logic [1:0]                     head_size
);
  import cbi_pkg::*;

  logic [ADDR_W-1:0]   q_addr [WQ_DEPTH];
  logic [DATA_W-1:0]   q_data [WQ_DEPTH];
  logic [1:0]          q_size [WQ_DEPTH];
  logic [WQ_PTR_W-1:0] wr_ptr;
  logic [WQ_PTR_W-1:0] rd_ptr;
  logic [WQ_PTR_W:0]   count;
  logic                do_push;
  logic                do_pop;

  assign do_push   = push && !full;
  assign do_pop    = pop && !empty;
  assign full      = (count == (WQ_PTR_W+1)'(WQ_DEPTH));
  assign empty     = (count == '0);
  assign head_addr = q_addr[rd_ptr];
  assign head_data = q_data[rd_ptr];
  assign head_size = q_size[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      q_addr[wr_ptr] <= push_addr;
      q_data[wr_ptr] <= push_data;
      q_size[wr_ptr] <= push_size;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= rd_ptr + 1'b1;
      case ({do_push, do_pop})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : cbi_write_queue
